/* smx_pkg.sv */
// smx_pkg: constants, types and register map of the max-address and block-size command block
// assumes a 32-bit AXI4-Lite register bus and byte addresses that are word aligned
package smx_pkg;
    // command codes
    localparam logic [7:0] CMD_SET_MAX_EXT = 8'h37;
    localparam logic [7:0] CMD_SET_MULT = 8'hC6;
    localparam logic [7:0] CMD_READ_NATIVE_EXT = 8'h27;
    // largest address reachable by 28-bit commands
    localparam logic [47:0] LBA28_LIMIT = 48'h0000_0FFF_FFFF;
    // block size after power-up and the largest accepted one
    localparam logic [7:0] BLK_DEFAULT = 8'h10;
    // error, status and sector count bit positions, and the status reset value
    localparam int ERR_ABORT_BIT = 2;
    localparam int STS_BSY_BIT = 7;
    localparam int STS_RDY_BIT = 6;
    localparam int STS_ERR_BIT = 0;
    localparam int SC_PERSIST_BIT = 0;
    localparam logic [7:0] STS_RESET = 8'h40;
    // register byte offsets and bus response codes
    localparam logic [7:0] REG_SECCNT = 8'h00;
    localparam logic [7:0] REG_LBA_CUR = 8'h04;
    localparam logic [7:0] REG_LBA_PREV = 8'h08;
    localparam logic [7:0] REG_COMMAND = 8'h0C;
    localparam logic [7:0] REG_DEVCTL = 8'h10;
    localparam logic [7:0] REG_ERROR = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;
    localparam logic [7:0] REG_LBA_OUT = 8'h1C;
    localparam logic [7:0] REG_ID61_60 = 8'h20;
    localparam logic [7:0] REG_ID101_100 = 8'h24;
    localparam logic [7:0] REG_ID103_102 = 8'h28;
    localparam logic [7:0] REG_MULT = 8'h2C;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [0:0] {CMD_IDLE, CMD_EXEC} smx_cmd_e;

    // task file as written by the host
    typedef struct packed {
        logic [7:0] secCntPrev;
        logic [7:0] secCntCur;
        logic [23:0] lbaPrev;
        logic [23:0] lbaCur;
        logic [7:0] command;
    } smx_task_s;

    // one write beat once both address and data are held
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } smx_wr_s;
endpackage

/* smx_max_block.sv */
// smx_max_block: decodes the 48-bit max-address set and the block-size command
// assumes capacity, security state and non-volatile store are provided by the drive around it
// What this block does
// RQ1: code 37h sets 48-bit max address
// RQ2: host reads native max just before set
// RQ3: abort set unless read-native came directly before
// RQ4: reject accesses beyond max with abort
// RQ5: above 28-bit limit update only words 103:100
// RQ6: at or below limit update both word groups
// RQ7: abort when unsupported or above capacity
// RQ8: abort when legacy protected area exists
// RQ9: abort when security locked or frozen
// RQ10: second non-volatile set aborted until power-on
// RQ11: sector count bit 0 selects persistence
// RQ12: address bytes split current low, previous high
// RQ13: return set address, high byte select chooses
// RQ14: code C6h sets multiple block size
// RQ15: power-up block size 16, multiple enabled
// RQ16: accept only 0,1,2,4,8,16
// RQ17: size 0 disables multiple commands
// RQ18: invalid size aborts and disables multiple
// RQ19: read-native flag guards set ordering
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module smx_max_block
    import smx_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [47:0] nativeMax,
    input wire logic featureSupported,
    input wire logic legacyAreaSet,
    input wire logic secLocked,
    input wire logic secFrozen,
    input wire logic nvValid,
    input wire logic [47:0] nvMaxAddr,
    input wire logic accessValid,
    input wire logic [47:0] accessLba,
    output logic accessReject,
    output logic nvStore,
    output logic [47:0] nvStoreAddr,
    output logic multEnable,
    output logic [7:0] blockSize
);
    function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // RQ16 legal sizes
    function automatic logic blockSizeOk(input logic [7:0] sz);
        return (sz == 8'h00) || (sz == 8'h01) || (sz == 8'h02) || (sz == 8'h04)
            || (sz == 8'h08) || (sz == BLK_DEFAULT);
    endfunction

    smx_task_s task_r;
    smx_wr_s wr_r;
    smx_cmd_e cmdState_r;
    logic awHeld_r, wHeld_r;
    logic hob_r;
    logic [7:0] error_r, status_r;
    logic [47:0] maxAddr_r, lbaRet_r, id103_100_r;
    logic [31:0] id61_60_r;
    logic nativeRead_r, nvDone_r, loaded_r;
    logic [47:0] reqAddr;
    logic setAbort, wrMapped, wrFire, rejectNow;

    // RQ12 byte order of the requested address
    assign reqAddr = {task_r.lbaPrev, task_r.lbaCur};
    // bvalid gates the fire so that a held pair lands once per write
    assign wrFire = awHeld_r && wHeld_r && !bvalid;
    assign wrMapped = (wr_r.addr <= REG_MULT) && (wr_r.addr[1:0] == 2'b00);
    // RQ4 access beyond the current maximum
    assign rejectNow = accessValid && loaded_r && (accessLba > maxAddr_r);

    // RQ3 RQ7 RQ8 RQ9 RQ10 abort causes
    assign setAbort = !nativeRead_r || !featureSupported || (reqAddr > nativeMax)
        || legacyAreaSet || secLocked || secFrozen
        || (task_r.secCntCur[SC_PERSIST_BIT] && nvDone_r);

    // address and data channels are taken in either order, one write at a time
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            wr_r <= '0;
        end else if (ce) begin
            if (awvalid && awready) begin
                awHeld_r <= 1'b1;
                awready <= 1'b0;
                wr_r.addr <= awaddr;
            end
            if (wvalid && wready) begin
                wHeld_r <= 1'b1;
                wready <= 1'b0;
                wr_r.data <= wdata;
                wr_r.strb <= wstrb;
            end
            if (wrFire) begin
                bvalid <= 1'b1;
                bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awHeld_r <= 1'b0;
                wHeld_r <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // task file and control writes
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            task_r <= '0;
            hob_r <= 1'b0;
        end else if (ce && wrFire && cmdState_r == CMD_IDLE) begin
            case (wr_r.addr)
                REG_SECCNT: begin
                    {task_r.secCntPrev, task_r.secCntCur} <=
                        16'(mergeBytes({16'h0000, task_r.secCntPrev, task_r.secCntCur},
                        wr_r.data, wr_r.strb));
                end
                REG_LBA_CUR: begin
                    task_r.lbaCur <= 24'(mergeBytes({8'h00, task_r.lbaCur}, wr_r.data, wr_r.strb));
                end
                REG_LBA_PREV: begin
                    task_r.lbaPrev <= 24'(mergeBytes({8'h00, task_r.lbaPrev}, wr_r.data,
                        wr_r.strb));
                end
                REG_COMMAND: begin
                    if (wr_r.strb[0]) begin
                        task_r.command <= wr_r.data[7:0];
                    end
                end
                REG_DEVCTL: begin
                    if (wr_r.strb[0]) begin
                        hob_r <= wr_r.data[0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // a command write makes the device busy for one cycle, then it executes
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cmdState_r <= CMD_IDLE;
        end else if (ce) begin
            case (cmdState_r)
                CMD_IDLE: begin
                    if (wrFire && wr_r.addr == REG_COMMAND && wr_r.strb[0]) begin
                        cmdState_r <= CMD_EXEC;
                    end
                end
                CMD_EXEC: cmdState_r <= CMD_IDLE;
                default: cmdState_r <= CMD_IDLE;
            endcase
        end
    end

    // capacity state; a persistent value is restored from the store after power-on
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            loaded_r <= 1'b0;
            maxAddr_r <= '0;
            id103_100_r <= '0;
            id61_60_r <= '0;
            lbaRet_r <= '0;
            nvDone_r <= 1'b0;
            nativeRead_r <= 1'b0;
            nvStore <= 1'b0;
            nvStoreAddr <= '0;
        end else if (ce) begin
            nvStore <= 1'b0;
            if (!loaded_r) begin
                // RQ11 persistent value survives power-on
                loaded_r <= 1'b1;
                maxAddr_r <= nvValid ? nvMaxAddr : nativeMax;
                id103_100_r <= nvValid ? nvMaxAddr : nativeMax;
                id61_60_r <= ((nvValid ? nvMaxAddr : nativeMax) > LBA28_LIMIT)
                    ? 32'(LBA28_LIMIT) : 32'(nvValid ? nvMaxAddr : nativeMax);
            end else if (cmdState_r == CMD_EXEC) begin
                // RQ19 flag lives for exactly the next command
                nativeRead_r <= (task_r.command == CMD_READ_NATIVE_EXT);
                if (task_r.command == CMD_READ_NATIVE_EXT) begin
                    lbaRet_r <= nativeMax;
                end
                // RQ1 set the new maximum
                if (task_r.command == CMD_SET_MAX_EXT && !setAbort) begin
                    maxAddr_r <= reqAddr;
                    lbaRet_r <= reqAddr;
                    id103_100_r <= reqAddr;
                    // RQ5 RQ6 low words only within 28-bit reach
                    if (reqAddr <= LBA28_LIMIT) begin
                        id61_60_r <= 32'(reqAddr);
                    end
                    // RQ10 RQ11 persistent request goes to store
                    if (task_r.secCntCur[SC_PERSIST_BIT]) begin
                        nvDone_r <= 1'b1;
                        nvStore <= 1'b1;
                        nvStoreAddr <= reqAddr;
                    end
                end
            end
        end
    end

    // block size; defaults restored by power-on only
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            // RQ15 power-up defaults
            blockSize <= BLK_DEFAULT;
            multEnable <= 1'b1;
        end else if (ce && cmdState_r == CMD_EXEC && task_r.command == CMD_SET_MULT) begin
            // RQ14 RQ17 RQ18 size taken or multiple disabled
            if (blockSizeOk(task_r.secCntCur)) begin
                blockSize <= task_r.secCntCur;
                multEnable <= (task_r.secCntCur != 8'h00);
            end else begin
                multEnable <= 1'b0;
            end
        end
    end

    // error and status; a rejected access also flags abort
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            error_r <= '0;
            status_r <= STS_RESET;
            accessReject <= 1'b0;
        end else if (ce) begin
            // RQ4 reject beyond the maximum
            accessReject <= rejectNow;
            if (cmdState_r == CMD_IDLE && wrFire && wr_r.addr == REG_COMMAND && wr_r.strb[0]) begin
                status_r <= 8'h80;
            end else if (cmdState_r == CMD_EXEC) begin
                if ((task_r.command == CMD_SET_MAX_EXT && setAbort)
                    || (task_r.command == CMD_SET_MULT && !blockSizeOk(task_r.secCntCur))) begin
                    error_r <= 8'h04;
                    status_r <= 8'h41;
                end else begin
                    error_r <= 8'h00;
                    status_r <= STS_RESET;
                end
            end
            // applied last so a rejection beside a completing command still sets the flags
            if (rejectNow) begin
                error_r[ERR_ABORT_BIT] <= 1'b1;
                status_r[STS_ERR_BIT] <= 1'b1;
            end
        end
    end

    // read channel: one read at a time, answered the cycle after it is taken
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (ce) begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rresp <= RESP_OKAY;
                case (araddr)
                    REG_SECCNT: rdata <= {16'h0000, task_r.secCntPrev, task_r.secCntCur};
                    REG_LBA_CUR: rdata <= {8'h00, task_r.lbaCur};
                    REG_LBA_PREV: rdata <= {8'h00, task_r.lbaPrev};
                    REG_COMMAND: rdata <= {24'h000000, task_r.command};
                    REG_DEVCTL: rdata <= {31'h00000000, hob_r};
                    REG_ERROR: rdata <= {24'h000000, error_r};
                    REG_STATUS: rdata <= {24'h000000, status_r};
                    // RQ13 high byte select picks the half
                    REG_LBA_OUT: rdata <= {8'h00, hob_r ? lbaRet_r[47:24] : lbaRet_r[23:0]};
                    REG_ID61_60: rdata <= id61_60_r;
                    REG_ID101_100: rdata <= id103_100_r[31:0];
                    REG_ID103_102: rdata <= {16'h0000, id103_100_r[47:32]};
                    REG_MULT: rdata <= {23'h000000, multEnable, blockSize};
                    default: begin
                        rdata <= '0;
                        rresp <= RESP_SLVERR;
                    end
                endcase
            end
            if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // a write without a matching read-native must never move the maximum
    property setNeedsNative;
        @(posedge clk) disable iff (!nrst)
        (ce && loaded_r && cmdState_r == CMD_EXEC && task_r.command == CMD_SET_MAX_EXT
            && !nativeRead_r) |=> $stable(maxAddr_r);
    endproperty
    set_order_a: assert property (setNeedsNative) else $error("set without native read"); // RQ3
    access_reject_a: assert property (@(posedge clk) disable iff (!nrst) // RQ4
        (ce && accessValid && loaded_r && accessLba > maxAddr_r) |=> accessReject)
        else $error("access beyond max not rejected");
    high_words_a: assert property (@(posedge clk) disable iff (!nrst) // RQ5
        (ce && loaded_r && cmdState_r == CMD_EXEC && task_r.command == CMD_SET_MAX_EXT
            && !setAbort && reqAddr > LBA28_LIMIT)
        |=> (id103_100_r == $past(reqAddr)) && $stable(id61_60_r))
        else $error("high identify update wrong");
    low_words_a: assert property (@(posedge clk) disable iff (!nrst) // RQ6
        (ce && loaded_r && cmdState_r == CMD_EXEC && task_r.command == CMD_SET_MAX_EXT
            && !setAbort && reqAddr <= LBA28_LIMIT)
        |=> (id61_60_r == 32'($past(reqAddr))) && (id103_100_r == $past(reqAddr)))
        else $error("low identify update wrong");
    set_abort_a: assert property (@(posedge clk) disable iff (!nrst) // RQ7
        (ce && cmdState_r == CMD_EXEC && task_r.command == CMD_SET_MAX_EXT && setAbort)
        |=> error_r[ERR_ABORT_BIT] && status_r[STS_ERR_BIT]) else $error("set not aborted");
    nv_once_a: assert property (@(posedge clk) disable iff (!nrst) // RQ10
        nvDone_r |=> !nvStore) else $error("second persistent set stored");
    mult_bad_a: assert property (@(posedge clk) disable iff (!nrst) // RQ18
        (ce && cmdState_r == CMD_EXEC && task_r.command == CMD_SET_MULT
            && !blockSizeOk(task_r.secCntCur))
        |=> !multEnable && error_r[ERR_ABORT_BIT]) else $error("bad block size kept");
    mult_zero_a: assert property (@(posedge clk) disable iff (!nrst) // RQ17
        (ce && cmdState_r == CMD_EXEC && task_r.command == CMD_SET_MULT
            && task_r.secCntCur == 8'h00) |=> !multEnable && blockSize == 8'h00)
        else $error("size zero left enabled");
    busy_one_a: assert property (@(posedge clk) disable iff (!nrst) // busy clears after one cycle
        (ce && status_r[STS_BSY_BIT] && cmdState_r == CMD_EXEC) |=> !status_r[STS_BSY_BIT])
        else $error("busy held too long");
    // the flag reflects only the command that has just executed
    native_flag_a: assert property (@(posedge clk) disable iff (!nrst) // RQ19
        (ce && loaded_r && cmdState_r == CMD_EXEC)
        |=> nativeRead_r == ($past(task_r.command) == CMD_READ_NATIVE_EXT))
        else $error("read-native flag wrong");
    set_ok_c: cover property (@(posedge clk) disable iff (!nrst)
        cmdState_r == CMD_EXEC && task_r.command == CMD_SET_MAX_EXT && !setAbort);
    nv_store_c: cover property (@(posedge clk) disable iff (!nrst) nvStore);
    mult_set_c: cover property (@(posedge clk) disable iff (!nrst)
        cmdState_r == CMD_EXEC && task_r.command == CMD_SET_MULT);
    reject_c: cover property (@(posedge clk) disable iff (!nrst) accessReject);
    nv_repeat_c: cover property (@(posedge clk) disable iff (!nrst)
        cmdState_r == CMD_EXEC && task_r.command == CMD_SET_MAX_EXT && nvDone_r);
endmodule // smx_max_block

/* smx_nv_store.sv */
// smx_nv_store: behavioural model of the drive's non-volatile store for the persisted max address
// assumes one-cycle store pulses from the block, sampled on the rising edge of clk
`timescale 1ns/1ps
module smx_nv_store (
    input wire logic clk,
    input wire logic nvStore,
    input wire logic [47:0] nvStoreAddr,
    output logic nvValid,
    output logic [47:0] nvMaxAddr
);
    initial begin
        nvValid = 1'b0;
        nvMaxAddr = 48'h0000_0000_0000;
    end
    // survives power-on reset
    // no reset input on purpose: the content must outlive nrst
    always @(posedge clk) begin
        if (nvStore === 1'b1) begin
            nvValid <= 1'b1;
            nvMaxAddr <= nvStoreAddr;
        end
    end
endmodule // smx_nv_store

/* smx_max_block_test.sv */
// smx_max_block_test: self-checking bench for the max-address and block-size commands
// assumes one write and one read outstanding on the bus and a drive capacity above 28 bits
`timescale 1ns/1ps
module smx_max_block_test
    import smx_pkg::*;
;
    localparam logic [47:0] NAT = 48'h0123_4567_89AB;
    localparam logic [47:0] V_HI = 48'h0012_3456_789A;
    localparam logic [47:0] V_LO = 48'h0000_0123_4567;
    localparam logic [47:0] V_P = 48'h0000_5555_AAAA;
    localparam logic [47:0] V_Q = 48'h0000_0777_1234;
    logic clk, nrst, ce, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, accessReject, nvStore, multEnable;
    logic featureSupported, legacyAreaSet, secLocked, secFrozen, nvValid, accessValid;
    logic [7:0] awaddr, araddr, blockSize;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, lastResp;
    logic [47:0] nativeMax, nvMaxAddr, accessLba, nvStoreAddr;
    int errCount = 0;
    int samplesChecked = 0;
    int nvPulses = 0;

    smx_max_block uut (.clk(clk), .nrst(nrst), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .nativeMax(nativeMax), .featureSupported(featureSupported),
        .legacyAreaSet(legacyAreaSet), .secLocked(secLocked), .secFrozen(secFrozen),
        .nvValid(nvValid), .nvMaxAddr(nvMaxAddr), .accessValid(accessValid),
        .accessLba(accessLba), .accessReject(accessReject), .nvStore(nvStore),
        .nvStoreAddr(nvStoreAddr), .multEnable(multEnable), .blockSize(blockSize));
    smx_nv_store store (.clk(clk), .nvStore(nvStore), .nvStoreAddr(nvStoreAddr),
        .nvValid(nvValid), .nvMaxAddr(nvMaxAddr));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) if (nvStore === 1'b1) nvPulses <= nvPulses + 1;

    task automatic tallyAndFinish();
        $display("comparisons %0d mismatches %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errCount++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // masters hold each channel until its own ready, then wait for the answer as long as it takes;
    // bready and rready stay high between transfers so back-to-back calls never toggle them
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic done;
        done = 1'b0;
        awaddr <= a; wdata <= d; wstrb <= 4'hF;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                lastResp = bresp;
                done = 1'b1;
            end
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic done;
        done = 1'b0;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                lastResp = rresp;
                done = 1'b1;
            end
        end
    endtask
    task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk({16'h0000, d}, {16'h0000, exp});
    endtask
    task automatic expect_done(input logic abort);
        expect_reg(REG_STATUS, abort ? 32'h0000_0041 : 32'h0000_0040);
        expect_reg(REG_ERROR, abort ? 32'h0000_0004 : 32'h0000_0000);
    endtask
    task automatic set_max(input logic [47:0] v, input logic persist, input logic pre);
        wr(REG_SECCNT, {31'h0000_0000, persist});
        wr(REG_LBA_CUR, {8'h00, v[23:0]});
        wr(REG_LBA_PREV, {8'h00, v[47:24]});
        if (pre) wr(REG_COMMAND, {24'h00_0000, CMD_READ_NATIVE_EXT});
        wr(REG_COMMAND, {24'h00_0000, CMD_SET_MAX_EXT});
    endtask
    task automatic probe(input logic [47:0] lba, input logic exp);
        accessLba <= lba;
        accessValid <= 1'b1;
        @(posedge clk);
        accessValid <= 1'b0;
        @(negedge clk);
        chk({47'h0, accessReject}, {47'h0, exp});
        @(posedge clk);
    endtask
    task automatic do_reset();
        nrst <= 1'b0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
    endtask

    task automatic t_reset();
        logic [31:0] d;
        expect_reg(REG_MULT, 32'h0000_0110);
        chk({47'h0, multEnable}, 48'h1);
        expect_reg(REG_ID101_100, NAT[31:0]);
        expect_reg(REG_ID103_102, {16'h0000, NAT[47:32]});
        expect_reg(REG_ID61_60, 32'h0FFF_FFFF);
        rd(8'h30, d);
        chk({46'h0, lastResp}, {46'h0, RESP_SLVERR});
        wr(8'h30, 32'h0000_00C6);
        chk({46'h0, lastResp}, {46'h0, RESP_SLVERR});
    endtask
    task automatic t_order();
        set_max(V_LO, 1'b0, 1'b0);
        expect_done(1'b1);
        wr(REG_COMMAND, {24'h00_0000, CMD_READ_NATIVE_EXT});
        wr(REG_DEVCTL, 32'h0000_0000);
        expect_reg(REG_LBA_OUT, {8'h00, NAT[23:0]});
        wr(REG_COMMAND, 32'h0000_00E5);
        wr(REG_COMMAND, {24'h00_0000, CMD_SET_MAX_EXT});
        expect_done(1'b1);
        expect_reg(REG_ID101_100, NAT[31:0]);
    endtask
    task automatic t_set_high();
        set_max(V_HI, 1'b0, 1'b1);
        expect_done(1'b0);
        expect_reg(REG_ID101_100, V_HI[31:0]);
        expect_reg(REG_ID103_102, {16'h0000, V_HI[47:32]});
        expect_reg(REG_ID61_60, 32'h0FFF_FFFF);
        expect_reg(REG_LBA_OUT, {8'h00, V_HI[23:0]});
        wr(REG_DEVCTL, 32'h0000_0001);
        expect_reg(REG_LBA_OUT, {8'h00, V_HI[47:24]});
        wr(REG_DEVCTL, 32'h0000_0000);
        probe(V_HI, 1'b0);
        probe(V_HI + 48'h1, 1'b1);
        expect_done(1'b1);
    endtask
    task automatic t_set_low();
        set_max(V_LO, 1'b0, 1'b1);
        expect_done(1'b0);
        expect_reg(REG_ID61_60, V_LO[31:0]);
        expect_reg(REG_ID101_100, V_LO[31:0]);
        expect_reg(REG_ID103_102, 32'h0000_0000);
        probe(V_HI, 1'b1);
    endtask
    // clock enable low freezes the access check too
    task automatic t_freeze();
        ce <= 1'b0;
        accessLba <= V_HI;
        accessValid <= 1'b1;
        repeat (3) @(posedge clk);
        accessValid <= 1'b0;
        ce <= 1'b1;
        @(negedge clk);
        chk({47'h0, accessReject}, 48'h0);
        @(posedge clk);
    endtask
    task automatic t_aborts();
        logic [3:0] env [5];
        env = '{4'b0000, 4'b1100, 4'b1010, 4'b1001, 4'b1000};
        for (int k = 0; k < 5; k++) begin
            {featureSupported, legacyAreaSet, secLocked, secFrozen} <= env[k];
            set_max((k == 4) ? NAT + 48'h1 : V_HI, 1'b0, 1'b1);
            expect_done(1'b1);
            expect_reg(REG_ID101_100, V_LO[31:0]);
        end
        {featureSupported, legacyAreaSet, secLocked, secFrozen} <= 4'b1000;
    endtask
    task automatic t_block_size();
        logic [7:0] sizes [8];
        logic [7:0] keep;
        logic ok;
        sizes = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h00, 8'h10, 8'h03, 8'h20};
        keep = BLK_DEFAULT;
        foreach (sizes[i]) begin
            ok = sizes[i] inside {8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10};
            if (ok) keep = sizes[i];
            wr(REG_SECCNT, {24'h00_0000, sizes[i]});
            wr(REG_COMMAND, {24'h00_0000, CMD_SET_MULT});
            expect_done(!ok);
            expect_reg(REG_MULT, {23'h0, ok && (keep != 8'h00), keep});
            chk({40'h0, blockSize}, {40'h0, keep});
            chk({47'h0, multEnable}, {47'h0, ok && (keep != 8'h00)});
        end
    endtask
    task automatic t_persist();
        set_max(V_P, 1'b1, 1'b1);
        expect_done(1'b0);
        chk(48'(nvPulses), 48'h1);
        chk(nvStoreAddr, V_P);
        set_max(V_P, 1'b1, 1'b1);
        expect_done(1'b1);
        chk(48'(nvPulses), 48'h1);
        do_reset();
        expect_reg(REG_ID101_100, V_P[31:0]);
        set_max(V_Q, 1'b0, 1'b1);
        expect_done(1'b0);
        do_reset();
        expect_reg(REG_ID101_100, V_P[31:0]);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        errCount++;
        tallyAndFinish();
    end
    initial begin
        nrst = 1'b0; ce = 1'b1; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
        arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00;
        wdata = 32'h0; wstrb = 4'h0; nativeMax = NAT; featureSupported = 1'b1;
        legacyAreaSet = 1'b0; secLocked = 1'b0; secFrozen = 1'b0;
        accessValid = 1'b0; accessLba = 48'h0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        t_reset();
        t_order();
        t_set_high();
        t_set_low();
        t_freeze();
        t_aborts();
        t_block_size();
        t_persist();
        tallyAndFinish();
    end
endmodule // smx_max_block_test
